// ### pkg/fpci_consts.svh
// Constants for the floating-point coprocessor integer-unit interface.
`ifndef FPCI_CONSTS_SVH
`define FPCI_CONSTS_SVH
`define FPCI_CC_EQUAL       2'h0
`define FPCI_CC_LESS        2'h1
`define FPCI_CC_GREATER     2'h2
`define FPCI_CC_UNORDERED   2'h3
`define FPCI_RESET_MIN_CYC  8
`define FPCI_PIN_IDLE       12'h07E
`define FPCI_OPF_LSB        5
`define FPCI_OPF_MSB        13
`define FPCI_OP3_LSB        19
`define FPCI_OP3_MSB        24
`define FPCI_OP3_FPOP1      6'h34
`define FPCI_OP3_FPOP2      6'h35
`define FPCI_OPF_FCMPS      9'h051
`define FPCI_OPF_FCMPES     9'h055
`define FPCI_OPF_FCMPD      9'h052
`define FPCI_OPF_FCMPED     9'h056
`define FPCI_OPF_FSMULD     9'h069
`define FPCI_OPF_FDMULX     9'h06E
`define FPCI_OPF_EXT_LOW    2'h3
`define FPCI_DWORD_MASK     32'h00000007
`define FPCI_WORD_MASK      32'h00000003
`endif

// ### pkg/fpci_pkg.sv
// Types for the floating-point coprocessor integer-unit interface.
package fpci_pkg;
  typedef enum logic [1:0] {
    FPCI_EXE_IDLE  = 2'b00,
    FPCI_EXE_BUSY  = 2'b01,
    FPCI_EXE_STORE = 2'b10,
    FPCI_EXE_WAIT  = 2'b11
  } fpci_exe_t;
endpackage : fpci_pkg

// ### rtl/fpci_iu_interface.sv
// Pin-level interface logic between the FP coprocessor, integer unit, peer and memory.
//
// Behaviour
// - Presence output is driven low at all times while the unit is fitted.
// - Condition code encodes equal, less, greater and unordered as 00, 01, 10, 11.
// - Condition-valid drops while a compare is pending, returns when it completes.
// - Decode-stage dependency conflict raises hold output on the following cycle.
// - Exception request stays asserted until acknowledge is sampled, then drops.
// - Fetch strobe loads bus into newer buffer, shifting old newer into older.
// - Newer-buffer dispatch loads newer buffer into the execute instruction register.
// - Older-buffer dispatch loads older buffer into the execute instruction register.
// - Flush discards instruction registers and stops store driving; queue untouched.
// - Peer hold passes a transparent latch and freezes the pipeline that cycle.
// - Peer condition-valid passes a transparent latch; low means a wait state.
// - Instruction address goes to decode address register, then newer address on fetch.
// - Store data drives the bus unlatched only during floating-point stores.
// - Doubleword stores off 8-byte and word stores off 4-byte boundaries flag an alignment error.
// - All data drivers are off while the data output enable is high.
// - Either memory hold input freezes the pipeline.
// - Memory data strobe loads bus data while the pipeline is held.
// - Extended-precision and mixed products trap as unimplemented.
// - Reset held eight cycles clears the pipeline and writable status fields.
`timescale 1ns/10ps
`include "fpci_consts.svh"

module fpci_iu_interface (
  input  wire logic        clock_i,                  // 200 MHz clock.
  input  wire logic        srst_i,                   // Synchronous reset, active high.
  input  wire logic        clk_en_i,                 // Clock enable; low freezes state.
  input  wire logic [31:0] addr_i,                   // Address bus.
  input  wire logic [31:0] data_i,                   // Data bus as seen at the pins.
  input  wire logic        fetch_strobe_i,           // Instruction fetch strobe.
  input  wire logic        dispatch_newer_buf_i,     // Execute the newer buffer.
  input  wire logic        dispatch_older_buf_i,     // Execute the older buffer.
  input  wire logic        flush_i,                  // Flush instruction registers.
  input  wire logic        exception_ack_i,          // Trap acknowledge.
  input  wire logic        peer_hold_n_i,            // Peer coprocessor hold, low active.
  input  wire logic        peer_cond_valid_i,        // Peer condition valid.
  input  wire logic        mem_hold_a_n_i,           // Memory hold A, low active.
  input  wire logic        mem_hold_b_n_i,           // Memory hold B, low active.
  input  wire logic        bus_grant_hold_n_i,       // Bus grant hold, low active.
  input  wire logic        mem_data_strobe_n_i,      // Memory data strobe, low active.
  input  wire logic        data_out_enable_n_i,      // Data output enable, low active.
  input  wire logic        dep_conflict_i,           // Decode dependency conflict from core.
  input  wire logic        cmp_issue_i,              // A compare enters the queue.
  input  wire logic        cmp_done_i,               // Oldest pending compare completes.
  input  wire logic [1:0]  cmp_result_i,             // Result code of completing compare.
  input  wire logic        fp_exception_i,           // Floating-point exception event.
  input  wire logic        store_active_i,           // Store data phase in progress.
  input  wire logic        store_double_i,           // Store is a doubleword.
  input  wire logic [63:0] store_data_i,             // Register file store data.
  output logic             unit_present_n_o,         // Presence, low when fitted.
  output logic [1:0]       cond_code_o,              // Condition code.
  output logic             cond_code_valid_o,        // Condition code valid.
  output logic             dependency_hold_n_o,      // Dependency hold, low active.
  output logic             exception_req_n_o,        // Exception request, low active.
  output logic [31:0]      data_o,                   // Store data to bus.
  output logic             data_oe_o,                // High while driving the data bus.
  output logic [31:0]      exec_instr_o,             // Execute-stage instruction.
  output logic             exec_valid_o,             // Execute instruction is valid.
  output logic [31:0]      exec_addr_o,              // Address of execute instruction.
  output logic             unimpl_trap_o,            // Unimplemented-op trap, one pulse.
  output logic             align_err_o,              // Misaligned store, high each cycle the store is active.
  output logic             pipe_frozen_o,            // Pipeline was frozen the previous cycle.
  output logic             peer_wait_o,              // Waiting on peer condition valid.
  output logic [31:0]      load_data_o,              // Data caught by memory data strobe.
  output logic             load_valid_o              // Load data caught, one pulse.
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [11:0] pin_s1_q, pin_s2_q, pin_s1_d;
  logic [31:0] addr_s1_q, addr_s2_q, data_s1_q, data_s2_q;

  // Collects the single-bit pins in a fixed order for the two-stage synchroniser.
  always_comb begin
    pin_s1_d = {fetch_strobe_i, dispatch_newer_buf_i, dispatch_older_buf_i, flush_i,
                exception_ack_i, peer_hold_n_i, peer_cond_valid_i, mem_hold_a_n_i,
                mem_hold_b_n_i, bus_grant_hold_n_i, mem_data_strobe_n_i,
                data_out_enable_n_i};
  end

  // Two flip-flops on the collected single-bit pins, address and data before any logic reads them.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pin_s1_q  <= `FPCI_PIN_IDLE;
      pin_s2_q  <= `FPCI_PIN_IDLE;
      addr_s1_q <= 32'h0;
      addr_s2_q <= 32'h0;
      data_s1_q <= 32'h0;
      data_s2_q <= 32'h0;
    end else if (clk_en_i) begin
      pin_s1_q  <= pin_s1_d;
      pin_s2_q  <= pin_s1_q;
      addr_s1_q <= addr_i;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= data_i;
      data_s2_q <= data_s1_q;
    end
  end

  logic fetch_s, disp1_s, disp2_s, flush_s, ack_s, peer_hold_n_s, peer_cv_s;
  logic mhold_a_n_s, mhold_b_n_s, bus_grant_hold_n_n_s, mds_n_s, doe_n_s;
  assign {fetch_s, disp1_s, disp2_s, flush_s, ack_s, peer_hold_n_s, peer_cv_s,
          mhold_a_n_s, mhold_b_n_s, bus_grant_hold_n_n_s, mds_n_s, doe_n_s} = pin_s2_q;

  // ----------------------------------------------------------------
  // Peer latches and freeze
  // ----------------------------------------------------------------
  logic peer_hold_lat, peer_cv_lat, freeze;

  // Transparent latches modelled as a pass while the clock is enabled, forced to no hold and valid otherwise.
  assign peer_hold_lat = clk_en_i ? ~peer_hold_n_s : 1'b0;
  assign peer_cv_lat   = clk_en_i ? peer_cv_s : 1'b1;
  // Any hold source stops the pipeline in the cycle it is seen.
  assign freeze = peer_hold_lat | ~mhold_a_n_s | ~mhold_b_n_s | ~bus_grant_hold_n_n_s;

  // ----------------------------------------------------------------
  // Instruction buffers and execute register
  // ----------------------------------------------------------------
  logic [31:0] newer_buf_q, older_buf_q, decode_addr_reg_q, newer_buf_addr_reg_q;
  logic [31:0] older_addr_q, exec_instr_q, exec_addr_q;
  logic        exec_valid_q;
  logic [31:0] newer_buf_d, older_buf_d, decode_addr_reg_d, newer_buf_addr_reg_d;
  logic [31:0] older_addr_d, exec_instr_d, exec_addr_d;
  logic        exec_valid_d, ext_op, unimpl_d, unimpl_q;
  logic [5:0]  op3;
  logic [8:0]  opf;

  // Decodes the execute instruction for operations this unit does not implement.
  always_comb begin
    op3    = exec_instr_q[`FPCI_OP3_MSB:`FPCI_OP3_LSB];
    opf    = exec_instr_q[`FPCI_OPF_MSB:`FPCI_OPF_LSB];
    ext_op = (op3 == `FPCI_OP3_FPOP1 || op3 == `FPCI_OP3_FPOP2) &&
             (opf[1:0] == `FPCI_OPF_EXT_LOW || opf[3:2] == `FPCI_OPF_EXT_LOW ||
              opf == `FPCI_OPF_FSMULD || opf == `FPCI_OPF_FDMULX);
  end

  // Fetch shift, dispatch and flush of the instruction registers.
  always_comb begin
    newer_buf_d          = newer_buf_q;
    older_buf_d          = older_buf_q;
    decode_addr_reg_d    = addr_s2_q;
    newer_buf_addr_reg_d = newer_buf_addr_reg_q;
    older_addr_d         = older_addr_q;
    exec_instr_d         = exec_instr_q;
    exec_addr_d          = exec_addr_q;
    exec_valid_d         = exec_valid_q;
    unimpl_d             = 1'b0;
    if (!freeze) begin
      if (fetch_s) begin
        newer_buf_d          = data_s2_q;
        older_buf_d          = newer_buf_q;
        newer_buf_addr_reg_d = decode_addr_reg_q;
        older_addr_d         = newer_buf_addr_reg_q;
      end
      if (disp1_s) begin
        exec_instr_d = newer_buf_q;
        exec_addr_d  = newer_buf_addr_reg_q;
        exec_valid_d = 1'b1;
      end else if (disp2_s) begin
        exec_instr_d = older_buf_q;
        exec_addr_d  = older_addr_q;
        exec_valid_d = 1'b1;
      end else begin
        exec_valid_d = 1'b0;
      end
      unimpl_d = exec_valid_q && ext_op;
    end
    if (flush_s) begin
      exec_valid_d = 1'b0;
      unimpl_d     = 1'b0;
    end
  end

  // Registers the instruction path; reset clears the pipeline.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      newer_buf_q          <= 32'h0;
      older_buf_q          <= 32'h0;
      decode_addr_reg_q    <= 32'h0;
      newer_buf_addr_reg_q <= 32'h0;
      older_addr_q         <= 32'h0;
      exec_instr_q         <= 32'h0;
      exec_addr_q          <= 32'h0;
      exec_valid_q         <= 1'b0;
      unimpl_q             <= 1'b0;
    end else if (clk_en_i) begin
      newer_buf_q          <= newer_buf_d;
      older_buf_q          <= older_buf_d;
      decode_addr_reg_q    <= decode_addr_reg_d;
      newer_buf_addr_reg_q <= newer_buf_addr_reg_d;
      older_addr_q         <= older_addr_d;
      exec_instr_q         <= exec_instr_d;
      exec_addr_q          <= exec_addr_d;
      exec_valid_q         <= exec_valid_d;
      unimpl_q             <= unimpl_d;
    end
  end

  // ----------------------------------------------------------------
  // Condition code, hold, exception and store control
  // ----------------------------------------------------------------
  logic [1:0]  cc_q, cc_d;
  logic [3:0]  cmp_pend_q, cmp_pend_d;
  logic        hold_q, hold_d, exc_q, exc_d, align_q, align_d;
  logic        load_v_q, load_v_d, wait_q, wait_d, frz_q, ccv_q, ccv_d;
  logic [31:0] dout_q, dout_d, load_q, load_d;
  logic        doe_q, doe_d;
  logic [1:0]  st_word_q, st_word_d;
  fpci_pkg::fpci_exe_t exe_q, exe_d;

  // Tracks pending compares, hold, exception handshake and the store data phase.
  always_comb begin
    cc_d       = cc_q;
    cmp_pend_d = cmp_pend_q;
    if (cmp_done_i && cmp_pend_q != 4'h0) begin
      cc_d       = cmp_result_i;
      cmp_pend_d = cmp_pend_q - 4'h1;
    end
    if (cmp_issue_i) begin
      cmp_pend_d = cmp_pend_d + 4'h1;
    end
    ccv_d = (cmp_pend_d == 4'h0);
    hold_d  = dep_conflict_i;
    // A new exception wins over the acknowledge clearing the old one.
    exc_d   = fp_exception_i | (exc_q & ~ack_s);
    wait_d  = ~peer_cv_lat;
    load_d  = load_q;
    load_v_d = 1'b0;
    if (freeze && !mds_n_s) begin
      load_d   = data_s2_q;
      load_v_d = 1'b1;
    end
    align_d = store_active_i && exe_q == fpci_pkg::FPCI_EXE_IDLE &&
              ((exec_addr_q & (store_double_i ? `FPCI_DWORD_MASK : `FPCI_WORD_MASK))
               != 32'h0);
    exe_d     = exe_q;
    st_word_d = st_word_q;
    case (exe_q)
      fpci_pkg::FPCI_EXE_IDLE: begin
        st_word_d = 2'h0;
        if (store_active_i && !align_d) begin
          exe_d = fpci_pkg::FPCI_EXE_STORE;
        end else if (!peer_cv_lat) begin
          exe_d = fpci_pkg::FPCI_EXE_WAIT;
        end
      end
      fpci_pkg::FPCI_EXE_STORE: begin
        if (!freeze) begin
          st_word_d = st_word_q + 2'h1;
        end
        if (!store_active_i || (!store_double_i && st_word_q != 2'h0) ||
            st_word_q == 2'h2) begin
          exe_d = fpci_pkg::FPCI_EXE_IDLE;
        end
      end
      fpci_pkg::FPCI_EXE_WAIT: begin
        if (peer_cv_lat) begin
          exe_d = fpci_pkg::FPCI_EXE_IDLE;
        end
      end
      default: begin
        exe_d = fpci_pkg::FPCI_EXE_IDLE;
      end
    endcase
    if (flush_s) begin
      exe_d = fpci_pkg::FPCI_EXE_IDLE;
    end
    // Store data leaves unlatched from the register file, upper word first.
    dout_d = (st_word_q == 2'h0) ? store_data_i[63:32] : store_data_i[31:0];
    doe_d  = exe_d == fpci_pkg::FPCI_EXE_STORE && !doe_n_s;
  end

  // Registers control state; reset clears pending compares and the handshake.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cc_q       <= `FPCI_CC_EQUAL;
      cmp_pend_q <= 4'h0;
      hold_q     <= 1'b0;
      exc_q      <= 1'b0;
      wait_q     <= 1'b0;
      load_q     <= 32'h0;
      load_v_q   <= 1'b0;
      align_q    <= 1'b0;
      exe_q      <= fpci_pkg::FPCI_EXE_IDLE;
      st_word_q  <= 2'h0;
      dout_q     <= 32'h0;
      doe_q      <= 1'b0;
      frz_q      <= 1'b0;
      ccv_q      <= 1'b1;
    end else if (clk_en_i) begin
      cc_q       <= cc_d;
      cmp_pend_q <= cmp_pend_d;
      hold_q     <= hold_d;
      exc_q      <= exc_d;
      wait_q     <= wait_d;
      load_q     <= load_d;
      load_v_q   <= load_v_d;
      align_q    <= align_d;
      exe_q      <= exe_d;
      st_word_q  <= st_word_d;
      dout_q     <= dout_d;
      doe_q      <= doe_d;
      frz_q      <= freeze;
      ccv_q      <= ccv_d;
    end
  end

  // Outputs straight from flip-flops, except presence, which is tied low.
  assign unit_present_n_o    = 1'b0;
  assign cond_code_o         = cc_q;
  assign cond_code_valid_o   = ccv_q;
  assign dependency_hold_n_o = ~hold_q;
  assign exception_req_n_o   = ~exc_q;
  assign data_o              = dout_q;
  assign data_oe_o           = doe_q;
  assign exec_instr_o        = exec_instr_q;
  assign exec_valid_o        = exec_valid_q;
  assign exec_addr_o         = exec_addr_q;
  assign unimpl_trap_o       = unimpl_q;
  assign align_err_o         = align_q;
  assign pipe_frozen_o       = frz_q;
  assign peer_wait_o         = wait_q;
  assign load_data_o         = load_q;
  assign load_valid_o        = load_v_q;

endmodule : fpci_iu_interface

// ### verification/fpci_iu_interface_asserts.sv
// Port assertions for the FP coprocessor interface block.
`timescale 1ns/10ps
module fpci_iu_chk (
  input wire logic       clock_i,             // Clock.
  input wire logic       srst_i,              // Reset.
  input wire logic       dep_conflict_i,      // Conflict.
  input wire logic       cmp_issue_i,         // Compare issue.
  input wire logic       cmp_done_i,          // Compare done.
  input wire logic [1:0] cmp_result_i,        // Compare code.
  input wire logic       fp_exception_i,      // Exception event.
  input wire logic       exception_ack_i,     // Acknowledge.
  input wire logic       store_active_i,      // Store phase.
  input wire logic       mem_hold_a_n_i,      // Memory hold.
  input wire logic       unit_present_n_o,    // Presence.
  input wire logic [1:0] cond_code_o,         // Code.
  input wire logic       cond_code_valid_o,   // Code valid.
  input wire logic       dependency_hold_n_o, // Hold.
  input wire logic       exception_req_n_o,   // Request.
  input wire logic       data_oe_o,           // Bus drive.
  input wire logic       pipe_frozen_o        // Frozen.
);
  // -----------------------------------------
  // Checks on one clock, idle during reset.
  // -----------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  a_present_low : assert property (unit_present_n_o == 1'b0)
    else $error("presence output not low");
  a_hold_next : assert property (dep_conflict_i |=> !dependency_hold_n_o)
    else $error("hold not raised after conflict");
  a_hold_release : assert property (dep_conflict_i ##1 !dep_conflict_i |=> dependency_hold_n_o)
    else $error("hold not released");
  a_exc_raise : assert property (fp_exception_i |=> !exception_req_n_o)
    else $error("exception request not raised");
  a_exc_holds : assert property (!exception_req_n_o && !$past(exception_ack_i, 2) |=> !exception_req_n_o)
    else $error("exception request dropped without acknowledge");
  a_exc_release : assert property ($rose(exception_req_n_o) |-> $past(exception_ack_i, 3))
    else $error("exception request released off the acknowledge timing");
  a_ccv_drop : assert property (cmp_issue_i && !cmp_done_i |=> !cond_code_valid_o)
    else $error("code valid high with a compare pending");
  a_ccv_return : assert property ($rose(cond_code_valid_o) |-> $past(cmp_done_i))
    else $error("code valid returned without a completion");
  a_cc_update : assert property (cmp_done_i |=> cond_code_o == $past(cmp_result_i))
    else $error("condition code not the completed result");
  a_oe_cause : assert property ($rose(data_oe_o) |-> $past(store_active_i))
    else $error("bus driven outside a store");
  a_hold_freeze : assert property (!$past(mem_hold_a_n_i, 3) && !$past(mem_hold_a_n_i, 4) |-> pipe_frozen_o)
    else $error("pipeline not frozen under memory hold");

  // Main scenarios reached.
  c_exc : cover property ($rose(exception_req_n_o));
  c_store : cover property ($rose(data_oe_o));
  c_cmp : cover property ($fell(cond_code_valid_o));
endmodule : fpci_iu_chk

bind fpci_iu_interface fpci_iu_chk chk_u (
  .clock_i, .srst_i, .dep_conflict_i, .cmp_issue_i, .cmp_done_i, .cmp_result_i,
  .fp_exception_i, .exception_ack_i, .store_active_i, .mem_hold_a_n_i, .unit_present_n_o,
  .cond_code_o, .cond_code_valid_o, .dependency_hold_n_o, .exception_req_n_o, .data_oe_o,
  .pipe_frozen_o
);

// ### verification/fpci_iu_model.sv
// Behavioural model of the integer unit side of the interface.
`timescale 1ns/10ps
module fpci_iu_model (
  input  wire logic       clock_i,           // Shared clock.
  input  wire logic       srst_i,            // Reset, active high.
  input  wire logic       exception_req_n_i, // Exception request, low active.
  input  wire logic [3:0] ack_delay_i,       // Cycles before the trap is taken.
  input  wire logic       flush_req_i,       // Bench request to flush.
  output logic            exception_ack_o,   // Trap acknowledge.
  output logic            flush_o            // Flush, straight from a register.
);
  logic [3:0] wait_q;

  // Takes the trap after a delay and holds acknowledge until the request drops.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wait_q <= 4'h0;
      exception_ack_o <= 1'b0;
      flush_o <= 1'b0;
    end else begin
      flush_o <= flush_req_i;
      if (exception_req_n_i) begin
        wait_q <= 4'h0;
        exception_ack_o <= 1'b0;
      end else if (wait_q >= ack_delay_i) begin
        exception_ack_o <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : fpci_iu_model

// ### verification/tb_top.sv
// Self-checking bench for the FP coprocessor interface block.
`timescale 1ns/10ps
`include "fpci_consts.svh"
module tb_top;
  logic        clock_i, srst_i, fetch_strobe_i, dispatch_newer_buf_i, dispatch_older_buf_i;
  logic        flush_i, exception_ack_i, peer_cond_valid_i, mem_data_strobe_n_i, flush_req;
  logic        data_out_enable_n_i, dep_conflict_i, cmp_issue_i, cmp_done_i, fp_exception_i;
  logic        store_active_i, store_double_i, unit_present_n_o, cond_code_valid_o, data_oe_o;
  logic        dependency_hold_n_o, exception_req_n_o, exec_valid_o, unimpl_trap_o;
  logic        align_err_o, pipe_frozen_o, peer_wait_o, load_valid_o;
  logic [1:0]  cmp_result_i, cond_code_o;
  logic [3:0]  hold_n, ack_dly;
  logic [15:0] lfsr_q;
  logic [31:0] addr_i, data_i, data_o, exec_instr_o, exec_addr_o, load_data_o;
  logic [63:0] store_data_i;
  int          n_fail, checked, cycles;

  fpci_iu_interface dut_u (
    .clock_i, .srst_i, .clk_en_i(1'b1), .addr_i, .data_i, .fetch_strobe_i,
    .dispatch_newer_buf_i, .dispatch_older_buf_i, .flush_i, .exception_ack_i,
    .peer_hold_n_i(hold_n[0]), .peer_cond_valid_i, .mem_hold_a_n_i(hold_n[1]),
    .mem_hold_b_n_i(hold_n[2]), .bus_grant_hold_n_i(hold_n[3]), .mem_data_strobe_n_i,
    .data_out_enable_n_i, .dep_conflict_i, .cmp_issue_i, .cmp_done_i, .cmp_result_i,
    .fp_exception_i, .store_active_i, .store_double_i, .store_data_i, .unit_present_n_o,
    .cond_code_o, .cond_code_valid_o, .dependency_hold_n_o, .exception_req_n_o, .data_o,
    .data_oe_o, .exec_instr_o, .exec_valid_o, .exec_addr_o, .unimpl_trap_o, .align_err_o,
    .pipe_frozen_o, .peer_wait_o, .load_data_o, .load_valid_o
  );
  fpci_iu_model iu_u (
    .clock_i, .srst_i, .exception_req_n_i(exception_req_n_o), .ack_delay_i(ack_dly),
    .flush_req_i(flush_req), .exception_ack_o(exception_ack_i), .flush_o(flush_i)
  );

  // Clock, and a cycle ceiling that cuts a hang short.
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  // Random words from a 16-bit shift register with a fixed start.
  function automatic logic [31:0] nxt();
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      r[i] = lfsr_q[0];
    end
    return r;
  endfunction : nxt
  // A single store sends the upper word only; a double sends upper then lower.
  function automatic logic [63:0] exp_store(input logic dbl, input logic [63:0] v);
    return dbl ? v : {32'h0, v[63:32]};
  endfunction : exp_store
  // Pins are held three cycles on each side of the strobe to cover the synchronisers.
  task automatic fetch(input logic [31:0] a, input logic [31:0] d);
    addr_i = a;
    data_i = d;
    cyc(3);
    fetch_strobe_i = 1'b1;
    cyc(1);
    fetch_strobe_i = 1'b0;
    cyc(3);
  endtask : fetch
  task automatic dispatch(input logic nw, input logic od, output logic [31:0] ins,
                          output logic [31:0] adr, output logic ut);
    ins = '1;
    ut = 1'b0;
    dispatch_newer_buf_i = nw;
    dispatch_older_buf_i = od;
    cyc(1);
    dispatch_newer_buf_i = 1'b0;
    dispatch_older_buf_i = 1'b0;
    repeat (8) begin
      cyc(1);
      ut = ut | (unimpl_trap_o === 1'b1);
      if (exec_valid_o === 1'b1) {ins, adr} = {exec_instr_o, exec_addr_o};
    end
  endtask : dispatch
  task automatic store(input logic dbl, input logic err, input logic off);
    logic [63:0] v, got;
    logic ae;
    v = {nxt(), nxt()};
    got = '0;
    ae = 1'b0;
    {store_double_i, store_data_i, store_active_i} = {dbl, v, 1'b1};
    for (int t = 0; t < 6; t++) begin
      cyc(1);
      if (t == dbl + 1) store_active_i = 1'b0;
      if (t > 0 && data_oe_o === 1'b1) got = {got[31:0], data_o};
      ae = ae | (align_err_o === 1'b1);
    end
    chk(got, (err | off) ? 64'h0 : exp_store(dbl, v), "store words");
    chk(ae, err, "align error");
  endtask : store

  // Main sequence.
  initial begin
    logic [31:0] a [2], d [2], ins, adr, off, got;
    logic [8:0] opf;
    logic ut, dbl;
    {srst_i, hold_n, peer_cond_valid_i, mem_data_strobe_n_i, lfsr_q} = {7'h7F, 16'hBFDF};
    {fetch_strobe_i, dispatch_newer_buf_i, dispatch_older_buf_i, flush_req, ack_dly} = '0;
    {data_out_enable_n_i, dep_conflict_i, cmp_issue_i, cmp_done_i, fp_exception_i} = '0;
    {store_active_i, store_double_i, cmp_result_i, addr_i, data_i, store_data_i} = '0;
    cyc(16);
    chk(unit_present_n_o, 1'b0, "presence");
    chk({cond_code_valid_o, dependency_hold_n_o, exception_req_n_o, data_oe_o}, 4'hE, "reset");
    srst_i = 1'b0;
    cyc(2);
    for (int i = 0; i < 9; i++) begin
      for (int j = 0; j < 2; j++) begin
        a[j] = nxt();
        d[j] = nxt() & 32'hFEFFFFFF;
        fetch(a[j], d[j]);
      end
      dispatch(i % 3 != 1, i % 3 != 0, ins, adr, ut);
      chk(ins, d[i % 3 == 1 ? 0 : 1], "exec instr");
      if (i % 3 != 1) chk(adr, a[1], "exec addr");
    end
    for (int k = 0; k < 4; k++) begin
      opf = k == 0 ? 9'h041 : k == 1 ? `FPCI_OPF_FSMULD : k == 2 ? `FPCI_OPF_FDMULX : 9'h043;
      fetch(32'h0, {2'h2, 5'h1, `FPCI_OP3_FPOP1, 5'h2, opf, 5'h3});
      dispatch(1'b1, 1'b0, ins, adr, ut);
      chk(ut, k != 0, "unimplemented trap");
    end
    for (int k = 0; k < 6; k++) begin
      off = k < 2 ? 32'h2 : k < 4 ? 32'h4 : 32'h0;
      dbl = k[0];
      fetch((nxt() & 32'hFFFFFFF8) | off, 32'h0);
      dispatch(1'b1, 1'b0, ins, adr, ut);
      store(dbl, (off & (dbl ? `FPCI_DWORD_MASK : `FPCI_WORD_MASK)) != 0, 1'b0);
    end
    data_out_enable_n_i = 1'b1;
    cyc(4);
    store(1'b1, 1'b0, 1'b1);
    {data_out_enable_n_i, flush_req} = 2'b01;
    cyc(5);
    store(1'b1, 1'b0, 1'b1);
    flush_req = 1'b0;
    cyc(5);
    for (int k = 0; k < 4; k++) begin
      {a[0], d[0]} = {nxt(), nxt() & 32'hFEFFFFFF};
      fetch(a[0], d[0]);
      hold_n[k] = 1'b0;
      cyc(4);
      chk(pipe_frozen_o, 1'b1, "frozen");
      {data_i, mem_data_strobe_n_i, got} = {nxt(), 1'b0, 32'hFFFFFFFF};
      cyc(1);
      mem_data_strobe_n_i = 1'b1;
      repeat (5) begin
        cyc(1);
        if (load_valid_o === 1'b1) got = load_data_o;
      end
      chk(got, data_i, "load data");
      fetch(nxt(), nxt());
      {addr_i, data_i} = {a[0], d[0]};
      hold_n[k] = 1'b1;
      cyc(4);
      dispatch(1'b1, 1'b0, ins, adr, ut);
      chk(ins, d[0], "fetch under hold");
    end
    for (int k = 0; k < 3; k++) begin
      {ack_dly, fp_exception_i} = {4'(k * 3), 1'b1};
      cyc(1);
      fp_exception_i = 1'b0;
      chk(exception_req_n_o, 1'b0, "exception raise");
      for (int t = 0; t < 30 && exception_req_n_o !== 1'b1; t++) cyc(1);
      chk(exception_req_n_o, 1'b1, "exception release");
      cyc(8);
    end
    for (int k = 0; k < 4; k++) begin
      cmp_issue_i = 1'b1;
      cyc(2);
      {cmp_issue_i, cmp_done_i, cmp_result_i} = {2'b01, 2'(3 - k)};
      cyc(1);
      chk(cond_code_valid_o, 1'b0, "valid while pending");
      cmp_result_i = k == 0 ? `FPCI_CC_EQUAL : k == 1 ? `FPCI_CC_LESS : 2'(k);
      cyc(1);
      cmp_done_i = 1'b0;
      chk({cond_code_valid_o, cond_code_o}, {1'b1, 2'(k)}, "compare result");
    end
    dep_conflict_i = 1'b1;
    cyc(1);
    dep_conflict_i = 1'b0;
    chk(dependency_hold_n_o, 1'b0, "dependency hold");
    peer_cond_valid_i = 1'b0;
    cyc(4);
    chk({peer_wait_o, dependency_hold_n_o}, 2'b11, "peer wait");
    peer_cond_valid_i = 1'b1;
    cyc(4);
    chk(peer_wait_o, 1'b0, "peer resume");
    conclude();
  end
endmodule : tb_top
